// ---- lbcl_pkg.sv ----
// Constants, command codes and bank states for the bank command legality block.
// Assumes a single 50 MHz clock; times are converted to whole clock cycles here.
package lbcl_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned NUM_BANKS = 4;
	localparam int unsigned CNT_W = 8;
	// Timing figures are plain defaults, to be set for the memory part in use
	localparam int unsigned PRECHARGE_TIME_NS = 15;
	localparam int unsigned ACTIVATE_TO_ACCESS_DELAY_NS = 15;
	localparam int unsigned REFRESH_CYCLE_TIME_NS = 72;
	localparam int unsigned MODE_LOAD_DELAY_NS = 10;
	localparam int unsigned WRITE_RECOVERY_NS = 15;
	localparam int unsigned BURST_LENGTH = 4;
	// Least times round up to whole cycles
	localparam int unsigned PRECHARGE_TIME_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ACTIVATE_TO_ACCESS_DELAY_CYC =
		(ACTIVATE_TO_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MODE_LOAD_DELAY_CYC = (MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BURST_CYC = BURST_LENGTH / 2;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

	typedef enum logic [3:0] {
		LBCL_CMD_DESELECT = 4'h0,
		LBCL_CMD_NOP = 4'h1,
		LBCL_CMD_ACTIVATE = 4'h2,
		LBCL_CMD_READ = 4'h3,
		LBCL_CMD_WRITE = 4'h4,
		LBCL_CMD_PRECHARGE = 4'h5,
		LBCL_CMD_TERMINATE = 4'h6,
		LBCL_CMD_REFRESH = 4'h7,
		LBCL_CMD_MODE_LOAD = 4'h8
	} lbcl_cmd_t;

	typedef enum logic [2:0] {
		LBCL_IDLE = 3'b000,
		LBCL_ACTIVATING = 3'b001,
		LBCL_ACTIVE = 3'b010,
		LBCL_READING = 3'b011,
		LBCL_WRITING = 3'b100,
		LBCL_PRECHARGING = 3'b101,
		LBCL_READING_AP = 3'b110,
		LBCL_WRITING_AP = 3'b111
	} lbcl_bank_state_t;

	typedef enum logic [1:0] {
		LBCL_DEV_FREE = 2'b00,
		LBCL_DEV_REFRESH = 2'b01,
		LBCL_DEV_MODE_LOAD = 2'b10,
		LBCL_DEV_PRECHARGE_ALL = 2'b11
	} lbcl_dev_state_t;
endpackage

// ---- lbcl_bank.sv ----
// One bank's state tracker with its own countdown timer.
// Assumes the top only sends a strobe for a decoded command aimed at this bank.
`timescale 1ns/10ps
module lbcl_bank #(
	parameter int unsigned RCD_CYC = lbcl_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC,
	parameter int unsigned RP_CYC = lbcl_pkg::PRECHARGE_TIME_CYC,
	parameter int unsigned BURST_CYC = lbcl_pkg::BURST_CYC,
	parameter int unsigned WR_CYC = lbcl_pkg::WRITE_RECOVERY_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic doAct,
	input wire logic doRead,
	input wire logic doWrite,
	input wire logic doPre,
	input wire logic allPre,
	input wire logic doTerm,
	input wire logic autoPre,
	output lbcl_pkg::lbcl_bank_state_t state,
	output logic illegal
);
	localparam logic [lbcl_pkg::CNT_W-1:0] RCD_LOAD = lbcl_pkg::CNT_W'(RCD_CYC - 1);
	localparam logic [lbcl_pkg::CNT_W-1:0] RP_LOAD = lbcl_pkg::CNT_W'(RP_CYC - 1);
	localparam logic [lbcl_pkg::CNT_W-1:0] BURST_LOAD = lbcl_pkg::CNT_W'(BURST_CYC - 1);
	localparam logic [lbcl_pkg::CNT_W-1:0] WR_AP_LOAD = lbcl_pkg::CNT_W'(BURST_CYC + WR_CYC - 1);

	logic [lbcl_pkg::CNT_W-1:0] cnt;
	logic ok;
	logic cntDone;

	assign cntDone = (cnt == lbcl_pkg::CNT_RESET);

	always_comb begin
		case (state)
			lbcl_pkg::LBCL_IDLE: ok = !(doRead || doWrite || doTerm || (doPre && !allPre));
			lbcl_pkg::LBCL_ACTIVE: ok = !(doAct || doTerm);
			lbcl_pkg::LBCL_READING: ok = !doAct;
			lbcl_pkg::LBCL_WRITING: ok = !(doAct || doTerm);
			default: ok = !(doAct || doRead || doWrite || doPre || doTerm);
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			illegal <= 1'b0;
		end else begin
			illegal <= !ok;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= lbcl_pkg::LBCL_IDLE;
			cnt <= lbcl_pkg::CNT_RESET;
		end else begin
			case (state)
				lbcl_pkg::LBCL_IDLE: begin
					if (doAct) begin
						state <= lbcl_pkg::LBCL_ACTIVATING;
						cnt <= RCD_LOAD;
					end
				end
				lbcl_pkg::LBCL_ACTIVATING: begin
					if (cntDone) begin
						state <= lbcl_pkg::LBCL_ACTIVE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				lbcl_pkg::LBCL_ACTIVE, lbcl_pkg::LBCL_READING, lbcl_pkg::LBCL_WRITING: begin
					if (doPre && ok) begin
						state <= lbcl_pkg::LBCL_PRECHARGING;
						cnt <= RP_LOAD;
					end else if (doRead) begin
						state <= autoPre ? lbcl_pkg::LBCL_READING_AP : lbcl_pkg::LBCL_READING;
						cnt <= BURST_LOAD;
					end else if (doWrite) begin
						state <= autoPre ? lbcl_pkg::LBCL_WRITING_AP : lbcl_pkg::LBCL_WRITING;
						cnt <= autoPre ? WR_AP_LOAD : BURST_LOAD;
					end else if (doTerm && ok) begin
						state <= lbcl_pkg::LBCL_ACTIVE;
					end else if (state != lbcl_pkg::LBCL_ACTIVE) begin
						if (cntDone) begin
							state <= lbcl_pkg::LBCL_ACTIVE;
						end else begin
							cnt <= cnt - 1'b1;
						end
					end
				end
				lbcl_pkg::LBCL_READING_AP, lbcl_pkg::LBCL_WRITING_AP: begin
					if (cntDone) begin
						state <= lbcl_pkg::LBCL_PRECHARGING;
						cnt <= RP_LOAD;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				lbcl_pkg::LBCL_PRECHARGING: begin
					if (cntDone) begin
						state <= lbcl_pkg::LBCL_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					state <= lbcl_pkg::LBCL_IDLE;
				end
			endcase
		end
	end

	// Dwell counter, read only by assertions
	logic [lbcl_pkg::CNT_W-1:0] dwell;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dwell <= lbcl_pkg::CNT_RESET;
		end else if (state != $past(state)) begin
			dwell <= lbcl_pkg::CNT_RESET;
		end else begin
			dwell <= dwell + 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_rd_ap_start;
		state == lbcl_pkg::LBCL_ACTIVE && doRead && autoPre && !doPre;
	endsequence
	sequence s_wr_ap_start;
		state == lbcl_pkg::LBCL_ACTIVE && doWrite && autoPre && !doPre && !doRead;
	endsequence

	a_act_enter: assert property (state == lbcl_pkg::LBCL_IDLE && doAct |=>
		state == lbcl_pkg::LBCL_ACTIVATING) else $error("activate not taken in idle");
	a_rcd_length: assert property ($past(state) == lbcl_pkg::LBCL_ACTIVATING &&
		state != lbcl_pkg::LBCL_ACTIVATING |-> state == lbcl_pkg::LBCL_ACTIVE && dwell == RCD_LOAD)
		else $error("activating period wrong length");
	a_rp_length: assert property ($past(state) == lbcl_pkg::LBCL_PRECHARGING &&
		state != lbcl_pkg::LBCL_PRECHARGING |-> state == lbcl_pkg::LBCL_IDLE && dwell == RP_LOAD)
		else $error("precharging period wrong length");
	a_rd_ap_path: assert property (s_rd_ap_start |=> state == lbcl_pkg::LBCL_READING_AP
		##1 (state == lbcl_pkg::LBCL_READING_AP || state == lbcl_pkg::LBCL_PRECHARGING))
		else $error("read with auto precharge path wrong");
	a_wr_ap_path: assert property (s_wr_ap_start |=> state == lbcl_pkg::LBCL_WRITING_AP
		##1 (state == lbcl_pkg::LBCL_WRITING_AP || state == lbcl_pkg::LBCL_PRECHARGING))
		else $error("write with auto precharge path wrong");
	a_busy_no_act: assert property (state == lbcl_pkg::LBCL_PRECHARGING && (doAct || doRead || doWrite) |=>
		illegal && state inside {lbcl_pkg::LBCL_PRECHARGING, lbcl_pkg::LBCL_IDLE})
		else $error("busy bank acted on a command");
	a_term_read: assert property (state == lbcl_pkg::LBCL_READING && doTerm && !doRead && !doWrite && !doPre
		|=> state == lbcl_pkg::LBCL_ACTIVE && !illegal) else $error("terminate did not end read");
endmodule

// ---- lbcl_legality.sv ----
// Command decoder and bank state tracker for a four-bank low-power DDR memory.
// Assumes command pins come from outside the clock domain; all pass two flip-flops.
`timescale 1ns/10ps
module lbcl_legality #(
	parameter int unsigned RCD_CYC = lbcl_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC,
	parameter int unsigned RP_CYC = lbcl_pkg::PRECHARGE_TIME_CYC,
	parameter int unsigned RFC_CYC = lbcl_pkg::REFRESH_CYCLE_TIME_CYC,
	parameter int unsigned MRD_CYC = lbcl_pkg::MODE_LOAD_DELAY_CYC,
	parameter int unsigned BURST_CYC = lbcl_pkg::BURST_CYC,
	parameter int unsigned WR_CYC = lbcl_pkg::WRITE_RECOVERY_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEnable,
	input wire logic chipSelect_b,
	input wire logic rowStrobe_b,
	input wire logic colStrobe_b,
	input wire logic writeEnable_b,
	input wire logic [1:0] bankAddr,
	input wire logic autoPreAll,
	output lbcl_pkg::lbcl_cmd_t cmdSeen,
	output logic [3*lbcl_pkg::NUM_BANKS-1:0] bankStates,
	output lbcl_pkg::lbcl_dev_state_t devState,
	output logic allIdle,
	output logic illegalCmd,
	output logic [1:0] lastReadBank
);
	// Timers count down to zero, so a count of zero cannot be served
	if (RCD_CYC < 1 || RP_CYC < 1 || RFC_CYC < 1 || MRD_CYC < 1 || BURST_CYC < 1) begin : g_count_low
		$error("cycle counts must be at least one");
	end
	if (RFC_CYC > 255 || BURST_CYC + WR_CYC > 255 || RCD_CYC > 255 || RP_CYC > 255 || MRD_CYC > 255) begin : g_count_high
		$error("cycle counts exceed timer width");
	end

	// Pin synchronisers; only the second stage is read
	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	logic ckePrev;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta <= 8'hFF;
			pinSync <= 8'hFF;
		end else begin
			pinMeta <= {clkEnable, chipSelect_b, rowStrobe_b, colStrobe_b, writeEnable_b, bankAddr, autoPreAll};
			pinSync <= pinMeta;
		end
	end

	logic ckeNow;
	logic [1:0] bankSel;
	logic a10;
	logic [3:0] pinCmd;
	assign ckeNow = pinSync[7];
	assign pinCmd = pinSync[6:3];
	assign bankSel = pinSync[2:1];
	assign a10 = pinSync[0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ckePrev <= 1'b0;
		end else begin
			ckePrev <= ckeNow;
		end
	end

	lbcl_pkg::lbcl_cmd_t cmd;
	always_comb begin
		case (pinCmd)
			4'b0111: cmd = lbcl_pkg::LBCL_CMD_NOP;
			4'b0011: cmd = lbcl_pkg::LBCL_CMD_ACTIVATE;
			4'b0101: cmd = lbcl_pkg::LBCL_CMD_READ;
			4'b0100: cmd = lbcl_pkg::LBCL_CMD_WRITE;
			4'b0010: cmd = lbcl_pkg::LBCL_CMD_PRECHARGE;
			4'b0110: cmd = lbcl_pkg::LBCL_CMD_TERMINATE;
			4'b0001: cmd = lbcl_pkg::LBCL_CMD_REFRESH;
			4'b0000: cmd = lbcl_pkg::LBCL_CMD_MODE_LOAD;
			default: cmd = lbcl_pkg::LBCL_CMD_DESELECT;
		endcase
	end

	// commands count only with clock enable high on this and the previous edge
	logic taken;
	logic devBusy;
	logic isExec;
	assign taken = ckeNow && ckePrev;
	assign devBusy = (devState != lbcl_pkg::LBCL_DEV_FREE);
	assign isExec = taken && cmd != lbcl_pkg::LBCL_CMD_NOP && cmd != lbcl_pkg::LBCL_CMD_DESELECT;

	logic [lbcl_pkg::NUM_BANKS-1:0] bankIdle;
	logic [lbcl_pkg::NUM_BANKS-1:0] bankIllegal;
	logic [lbcl_pkg::NUM_BANKS-1:0] bankPreOk;
	logic allIdleNow;
	logic preAllOk;
	logic devIllegal;
	assign allIdleNow = &bankIdle;
	assign preAllOk = &bankPreOk;

	// device-wide operations; a busy device flags every executable command
	always_comb begin
		devIllegal = 1'b0;
		if (isExec && devBusy) begin
			devIllegal = 1'b1;
		end else if (isExec && (cmd == lbcl_pkg::LBCL_CMD_REFRESH || cmd == lbcl_pkg::LBCL_CMD_MODE_LOAD)) begin
			devIllegal = !allIdleNow;
		end else if (isExec && cmd == lbcl_pkg::LBCL_CMD_PRECHARGE && a10) begin
			devIllegal = !preAllOk;
		end
	end

	// each bank sees commands aimed at it by bankSel; terminate goes to lastReadBank and precharge all to every bank when all may take it
	genvar gi;
	generate
		for (gi = 0; gi < lbcl_pkg::NUM_BANKS; gi++) begin : g_bank
			logic hit;
			logic term;
			lbcl_pkg::lbcl_bank_state_t bs;
			assign hit = isExec && !devBusy && (bankSel == 2'(gi));
			assign term = isExec && !devBusy && cmd == lbcl_pkg::LBCL_CMD_TERMINATE && (lastReadBank == 2'(gi));
			assign bankIdle[gi] = (bs == lbcl_pkg::LBCL_IDLE);
			assign bankPreOk[gi] = bs inside {lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_ACTIVE,
				lbcl_pkg::LBCL_READING, lbcl_pkg::LBCL_WRITING};
			assign bankStates[3*gi +: 3] = bs;
			// per-bank tracker; precharge all reaches every bank only when all may take it
			lbcl_bank #(
				.RCD_CYC(RCD_CYC),
				.RP_CYC(RP_CYC),
				.BURST_CYC(BURST_CYC),
				.WR_CYC(WR_CYC)
			) u_bank (
				.clk(clk),
				.rst_b(rst_b),
				.doAct(hit && cmd == lbcl_pkg::LBCL_CMD_ACTIVATE),
				.doRead(hit && cmd == lbcl_pkg::LBCL_CMD_READ),
				.doWrite(hit && cmd == lbcl_pkg::LBCL_CMD_WRITE),
				.doPre(cmd == lbcl_pkg::LBCL_CMD_PRECHARGE && isExec && !devBusy && (a10 ? preAllOk : hit)),
				.allPre(a10),
				.doTerm(term),
				.autoPre(a10),
				.state(bs),
				.illegal(bankIllegal[gi])
			);
		end
	endgenerate

	logic [lbcl_pkg::CNT_W-1:0] devCnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			devState <= lbcl_pkg::LBCL_DEV_FREE;
			devCnt <= lbcl_pkg::CNT_RESET;
		end else if (devBusy) begin
			if (devCnt == lbcl_pkg::CNT_RESET) begin
				devState <= lbcl_pkg::LBCL_DEV_FREE;
			end else begin
				devCnt <= devCnt - 1'b1;
			end
		end else if (isExec && !devIllegal) begin
			case (cmd)
				lbcl_pkg::LBCL_CMD_REFRESH: begin
					devState <= lbcl_pkg::LBCL_DEV_REFRESH;
					devCnt <= lbcl_pkg::CNT_W'(RFC_CYC - 1);
				end
				lbcl_pkg::LBCL_CMD_MODE_LOAD: begin
					devState <= lbcl_pkg::LBCL_DEV_MODE_LOAD;
					devCnt <= lbcl_pkg::CNT_W'(MRD_CYC - 1);
				end
				lbcl_pkg::LBCL_CMD_PRECHARGE: begin
					if (a10) begin
						devState <= lbcl_pkg::LBCL_DEV_PRECHARGE_ALL;
						devCnt <= lbcl_pkg::CNT_W'(RP_CYC - 1);
					end
				end
				default: begin
					devState <= devState;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lastReadBank <= 2'h0;
		end else if (isExec && !devBusy && cmd == lbcl_pkg::LBCL_CMD_READ && bankPreOk[bankSel] && !bankIdle[bankSel]) begin
			lastReadBank <= bankSel;
		end
	end

	// one-cycle flag; bank flags already lag one cycle, so device flag is delayed to match
	logic devIllegalQ;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			devIllegalQ <= 1'b0;
			illegalCmd <= 1'b0;
			cmdSeen <= lbcl_pkg::LBCL_CMD_DESELECT;
			allIdle <= 1'b1;
		end else begin
			devIllegalQ <= devIllegal;
			illegalCmd <= devIllegalQ || (|bankIllegal);
			cmdSeen <= taken ? cmd : lbcl_pkg::LBCL_CMD_DESELECT;
			allIdle <= allIdleNow && !devBusy;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_decode_act: assert property (taken && pinCmd == 4'b0011 |=>
		cmdSeen == lbcl_pkg::LBCL_CMD_ACTIVATE) else $error("activate pattern misdecoded");
	a_nop_no_flag: assert property (taken && cmd == lbcl_pkg::LBCL_CMD_NOP |=>
		!devIllegalQ) else $error("no_operation was flagged");
	a_refresh_start: assert property (isExec && !devBusy && cmd == lbcl_pkg::LBCL_CMD_REFRESH && allIdleNow |=>
		devState == lbcl_pkg::LBCL_DEV_REFRESH) else $error("refresh not started");
	a_mode_start: assert property (isExec && !devBusy && cmd == lbcl_pkg::LBCL_CMD_MODE_LOAD && allIdleNow |=>
		devState == lbcl_pkg::LBCL_DEV_MODE_LOAD) else $error("mode load not started");
	a_preall_idle: assert property (devState == lbcl_pkg::LBCL_DEV_PRECHARGE_ALL && devCnt == 8'h00 |=>
		devState == lbcl_pkg::LBCL_DEV_FREE && allIdleNow) else $error("banks not idle after precharge all");
	a_busy_flags: assert property (devBusy && isExec |=> ##1 illegalCmd)
		else $error("command during device busy not flagged");
endmodule

// ---- lbcl_ctrl_model.sv ----
// Memory controller model that puts commands on the pins of the legality block.
// Assumes the bench orders commands; pins change only at falling clock edges.
`timescale 1ns/10ps
module lbcl_ctrl_model (
	input wire logic clk,
	output logic clkEnable,
	output logic chipSelect_b,
	output logic rowStrobe_b,
	output logic colStrobe_b,
	output logic writeEnable_b,
	output logic [1:0] bankAddr,
	output logic autoPreAll
);
	initial begin
		clkEnable = 1'h1;
		chipSelect_b = 1'h1;
		rowStrobe_b = 1'h1;
		colStrobe_b = 1'h0;
		writeEnable_b = 1'h1;
		bankAddr = 2'h0;
		autoPreAll = 1'h0;
	end

	// Pins are held a whole cycle so the sampling edge sees settled levels
	task automatic send(input lbcl_pkg::lbcl_cmd_t cmd, input logic [1:0] bank, input logic ap);
		logic [2:0] pins;
		@(negedge clk);
		case (cmd)
			lbcl_pkg::LBCL_CMD_ACTIVATE: pins = 3'h3;
			lbcl_pkg::LBCL_CMD_READ: pins = 3'h5;
			lbcl_pkg::LBCL_CMD_WRITE: pins = 3'h4;
			lbcl_pkg::LBCL_CMD_PRECHARGE: pins = 3'h2;
			lbcl_pkg::LBCL_CMD_TERMINATE: pins = 3'h6;
			lbcl_pkg::LBCL_CMD_REFRESH: pins = 3'h1;
			lbcl_pkg::LBCL_CMD_MODE_LOAD: pins = 3'h0;
			default: pins = 3'h7;
		endcase
		if (cmd == lbcl_pkg::LBCL_CMD_DESELECT) begin
			pins = ~{rowStrobe_b, colStrobe_b, writeEnable_b};
		end
		chipSelect_b = (cmd == lbcl_pkg::LBCL_CMD_DESELECT);
		{rowStrobe_b, colStrobe_b, writeEnable_b} = pins;
		bankAddr = bank;
		autoPreAll = ap;
	endtask

	task automatic setCke(input logic level);
		@(negedge clk);
		clkEnable = level;
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the bank command legality block.
// Assumes short timing parameters below; every check waits from a falling edge.
`timescale 1ns/10ps
module tb;
	localparam int unsigned RCD = 2;
	localparam int unsigned RP = 2;
	localparam int unsigned RFC = 10;
	localparam int unsigned MRD = 4;
	localparam int unsigned BURST = 16;
	localparam int unsigned WRC = 1;
	logic clk;
	logic rst_b;
	logic clkEnable, chipSelect_b, rowStrobe_b, colStrobe_b, writeEnable_b, autoPreAll;
	logic [1:0] bankAddr;
	lbcl_pkg::lbcl_cmd_t cmdSeen;
	logic [11:0] bankStates;
	lbcl_pkg::lbcl_dev_state_t devState;
	logic allIdle, illegalCmd;
	logic [1:0] lastReadBank;
	int n_mismatch = 0;
	int checks_done = 0;

	initial clk = 1'h0;
	always #10 clk = ~clk;

	lbcl_ctrl_model i_ctrl (.clk(clk), .clkEnable(clkEnable), .chipSelect_b(chipSelect_b),
		.rowStrobe_b(rowStrobe_b), .colStrobe_b(colStrobe_b), .writeEnable_b(writeEnable_b),
		.bankAddr(bankAddr), .autoPreAll(autoPreAll));

	lbcl_legality #(.RCD_CYC(RCD), .RP_CYC(RP), .RFC_CYC(RFC), .MRD_CYC(MRD), .BURST_CYC(BURST),
		.WR_CYC(WRC)) i_dut (.clk(clk), .rst_b(rst_b), .clkEnable(clkEnable),
		.chipSelect_b(chipSelect_b), .rowStrobe_b(rowStrobe_b), .colStrobe_b(colStrobe_b),
		.writeEnable_b(writeEnable_b), .bankAddr(bankAddr), .autoPreAll(autoPreAll),
		.cmdSeen(cmdSeen), .bankStates(bankStates), .devState(devState), .allIdle(allIdle),
		.illegalCmd(illegalCmd), .lastReadBank(lastReadBank));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkFlag(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	function automatic logic [3:0] st(input int b);
		return {1'h0, bankStates[3*b +: 3]};
	endfunction

	// Command then no_operation; results land two edges on, the flag one later
	task automatic step(input lbcl_pkg::lbcl_cmd_t c, input logic [1:0] b, input logic ap,
		input lbcl_pkg::lbcl_bank_state_t es, input lbcl_pkg::lbcl_dev_state_t ed, input logic bad);
		i_ctrl.send(c, b, ap);
		i_ctrl.send(lbcl_pkg::LBCL_CMD_NOP, 2'h0, 1'h0);
		repeat (2) @(negedge clk);
		chk("cmdSeen", c, cmdSeen);
		chk("bank state", {1'h0, es}, st(b));
		chk("devState", {2'h0, ed}, {2'h0, devState});
		@(negedge clk);
		chkFlag("illegalCmd", bad, illegalCmd);
	endtask

	task automatic waitSt(input int b, input lbcl_pkg::lbcl_bank_state_t es);
		int i;
		for (i = 0; i < 60 && st(b) !== {1'h0, es}; i++) begin
			@(negedge clk);
		end
		chk("settled state", {1'h0, es}, st(b));
		if (i == 60) begin
			print_verdict();
		end
	endtask

	// Device free, then all idle one cycle later
	task automatic waitFree();
		int i;
		for (i = 0; i < 60 && devState !== lbcl_pkg::LBCL_DEV_FREE; i++) begin
			@(negedge clk);
		end
		@(negedge clk);
		chkFlag("allIdle", 1'h1, allIdle);
		if (i == 60) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	task automatic tsReset();
		repeat (12) @(negedge clk);
		chk("cmdSeen", lbcl_pkg::LBCL_CMD_DESELECT, cmdSeen);
		chk("bankStates", 4'h0, bankStates[3:0] | bankStates[7:4] | bankStates[11:8]);
		chk("devState", {2'h0, lbcl_pkg::LBCL_DEV_FREE}, {2'h0, devState});
		chkFlag("allIdle", 1'h1, allIdle);
		chkFlag("illegalCmd", 1'h0, illegalCmd);
		chk("lastReadBank", 4'h0, {2'h0, lastReadBank});
		@(negedge clk);
		rst_b = 1'h1;
	endtask

	task automatic tsRefused();
		step(lbcl_pkg::LBCL_CMD_READ, 2'h0, 1'h0, lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_DEV_FREE, 1'h1);
		i_ctrl.setCke(1'h0);
		i_ctrl.send(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h3, 1'h0);
		i_ctrl.send(lbcl_pkg::LBCL_CMD_NOP, 2'h0, 1'h0);
		i_ctrl.setCke(1'h1);
		repeat (2) @(negedge clk);
		chk("cmdSeen", lbcl_pkg::LBCL_CMD_DESELECT, cmdSeen);
		chk("bank state", {1'h0, lbcl_pkg::LBCL_IDLE}, st(3));
		@(negedge clk);
		chkFlag("illegalCmd", 1'h0, illegalCmd);
		repeat (3) @(negedge clk);
	endtask

	task automatic tsDevice();
		step(lbcl_pkg::LBCL_CMD_REFRESH, 2'h0, 1'h0, lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_DEV_REFRESH, 1'h0);
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h0, 1'h0, lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_DEV_REFRESH, 1'h1);
		waitFree();
		step(lbcl_pkg::LBCL_CMD_MODE_LOAD, 2'h0, 1'h0, lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_DEV_MODE_LOAD, 1'h0);
		waitFree();
	endtask

	task automatic tsRowFlow();
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h1, 1'h0, lbcl_pkg::LBCL_ACTIVATING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		chk("bank state", {1'h0, lbcl_pkg::LBCL_ACTIVATING}, st(1));
		@(negedge clk);
		chk("bank state", {1'h0, lbcl_pkg::LBCL_ACTIVE}, st(1));
		step(lbcl_pkg::LBCL_CMD_READ, 2'h1, 1'h0, lbcl_pkg::LBCL_READING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		chk("lastReadBank", 4'h1, {2'h0, lastReadBank});
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h2, 1'h0, lbcl_pkg::LBCL_ACTIVATING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		step(lbcl_pkg::LBCL_CMD_TERMINATE, 2'h3, 1'h0, lbcl_pkg::LBCL_IDLE, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		chk("bank state", {1'h0, lbcl_pkg::LBCL_ACTIVE}, st(1));
		step(lbcl_pkg::LBCL_CMD_WRITE, 2'h1, 1'h0, lbcl_pkg::LBCL_WRITING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		step(lbcl_pkg::LBCL_CMD_READ, 2'h1, 1'h0, lbcl_pkg::LBCL_READING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		step(lbcl_pkg::LBCL_CMD_PRECHARGE, 2'h1, 1'h0, lbcl_pkg::LBCL_PRECHARGING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		waitSt(1, lbcl_pkg::LBCL_IDLE);
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h1, 1'h0, lbcl_pkg::LBCL_ACTIVATING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		repeat (RCD) @(negedge clk);
		i_ctrl.send(lbcl_pkg::LBCL_CMD_PRECHARGE, 2'h1, 1'h0);
		// Activate lands while the bank is still precharging
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h1, 1'h0, lbcl_pkg::LBCL_PRECHARGING, lbcl_pkg::LBCL_DEV_FREE, 1'h1);
		waitSt(1, lbcl_pkg::LBCL_IDLE);
	endtask

	task automatic tsAutoPre();
		step(lbcl_pkg::LBCL_CMD_WRITE, 2'h2, 1'h1, lbcl_pkg::LBCL_WRITING_AP, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		waitSt(2, lbcl_pkg::LBCL_IDLE);
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h3, 1'h0, lbcl_pkg::LBCL_ACTIVATING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		repeat (RCD) @(negedge clk);
		step(lbcl_pkg::LBCL_CMD_READ, 2'h3, 1'h1, lbcl_pkg::LBCL_READING_AP, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		step(lbcl_pkg::LBCL_CMD_ACTIVATE, 2'h0, 1'h0, lbcl_pkg::LBCL_ACTIVATING, lbcl_pkg::LBCL_DEV_FREE, 1'h0);
		chk("lastReadBank", 4'h3, {2'h0, lastReadBank});
		waitSt(3, lbcl_pkg::LBCL_PRECHARGING);
		waitSt(3, lbcl_pkg::LBCL_IDLE);
	endtask

	task automatic tsBusy();
		step(lbcl_pkg::LBCL_CMD_REFRESH, 2'h0, 1'h0, lbcl_pkg::LBCL_ACTIVE, lbcl_pkg::LBCL_DEV_FREE, 1'h1);
		step(lbcl_pkg::LBCL_CMD_PRECHARGE, 2'h0, 1'h1, lbcl_pkg::LBCL_PRECHARGING,
			lbcl_pkg::LBCL_DEV_PRECHARGE_ALL, 1'h0);
		waitFree();
		chk("bank state", {1'h0, lbcl_pkg::LBCL_IDLE}, st(0));
	endtask

	initial begin
		rst_b = 1'h0;
		tsReset();
		tsRefused();
		tsDevice();
		tsRowFlow();
		tsAutoPre();
		tsBusy();
		print_verdict();
	end

	// Hang guard: counts as a mismatch
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule
